// ### hw/spi_switch_pkg.sv
// Constants and carrier types for the serial switch register bank.
// Assumes one register bank per device, reached only over the serial port.
package spi_switch_pkg;

    // ----------------------------------------
    // Register map
    // ----------------------------------------
    localparam logic [6:0] ADDR_SW    = 7'h01;
    localparam logic [6:0] ADDR_CFG   = 7'h02;
    localparam logic [6:0] ADDR_FLAGS = 7'h03;
    localparam logic [6:0] ADDR_BURST = 7'h05;
    localparam logic [6:0] ADDR_KEY   = 7'h0B;

    localparam logic [7:0] SW_RST     = 8'h00;
    localparam logic [7:0] CFG_RST    = 8'h06;
    localparam logic [7:0] FLAGS_RST  = 8'h00;
    localparam logic [7:0] BURST_RST  = 8'h00;
    localparam logic [7:0] KEY_RST    = 8'h00;
    localparam logic [7:0] CFG_MASK   = 8'h07;
    localparam logic [7:0] BURST_MASK = 8'h01;

    // ----------------------------------------
    // Field positions
    // ----------------------------------------
    localparam int CFG_CRC_BIT  = 0;
    localparam int CFG_SCLK_BIT = 1;
    localparam int CFG_RW_BIT   = 2;
    localparam int FLAG_CRC     = 0;
    localparam int FLAG_SCLK    = 1;
    localparam int FLAG_RW      = 2;
    localparam int BURST_BIT    = 0;

    // ----------------------------------------
    // Frame constants
    // ----------------------------------------
    localparam logic [15:0] CLEAR_WORD = 16'h6CA9;
    localparam logic [7:0]  KEY_FIRST  = 8'hA3;
    localparam logic [7:0]  KEY_SECOND = 8'h05;
    localparam logic [7:0]  ALIGN_BYTE = 8'h25;
    localparam logic [7:0]  CRC_POLY   = 8'h07;
    localparam logic [7:0]  CRC_SEED   = 8'h00;
    localparam logic [5:0]  LEN_PLAIN  = 6'h10;
    localparam logic [5:0]  LEN_CRC    = 6'h18;
    localparam logic [5:0]  IDX_MAX    = 6'h3F;
    localparam logic [5:0]  IDX_ADDR   = 6'h07;

    // One command word as shifted in
    typedef struct packed {
        logic       rd;
        logic [6:0] addr;
        logic [7:0] data;
    } cmd_t;

    // Serial pins as sampled together
    typedef struct packed {
        logic sclk;
        logic cs_n;
        logic sdi;
    } pins_t;

    localparam pins_t PINS_IDLE = 3'h2;

endpackage

// ### hw/spi_switch_register_bank.sv
// Register bank and serial slave of an octal switch device.
// Assumes the serial pins are asynchronous to mclk and sclk is slow
// enough (80 ns or more) to be oversampled by the 5 ns clock.
`timescale 1ns/1ps

// Behaviour
// - Eight-bit switch register; bit n-1 closes switch n when one.
// - Switch register clears to zero on reset, all switches open.
// - Error config resets with address and clock checks on, CRC off.
// - Config bit 2 enables flagging of invalid register addresses.
// - Config bit 1 enables checking the clock count of each frame.
// - Without burst, a frame must hold 16 clocks, or 24 with CRC.
// - With burst, a frame holds a multiple of 16, or 24 with CRC.
// - Config bit 0 enables CRC; commands then carry a trailing CRC byte.
// - Config bits 7 to 3 read as zero; host writes zeros.
// - Clear word empties the error flags, never an address error, needs a valid CRC only when CRC is on.
// - Writes to read-only registers are blocked and flagged as bad address.
// - Short frames write nothing and raise the clock-count flag.
// - Burst bit 0 lets several commands share one chip-select frame.
module spi_switch_register_bank
    import spi_switch_pkg::*;
(
    input  wire logic       mclk,
    input  wire logic       sys_rst,
    input  wire logic       sclk,
    input  wire logic       cs_n,
    input  wire logic       sdi,
    output logic            sdo_out,
    output logic            sdo_oe_n,
    output logic [7:0]      switch_close
);

    // ----------------------------------------
    // Declarations
    // ----------------------------------------
    pins_t       sync1_reg;
    pins_t       sync2_reg;
    logic        sclk_prev_reg;
    logic        cs_prev_reg;
    logic [7:0]  sw_reg;
    logic [7:0]  cfg_reg;
    logic [7:0]  flags_reg;
    logic [7:0]  flags_next;
    logic [7:0]  burst_reg;
    logic [7:0]  key_reg;
    logic [23:0] rx_reg;
    logic [23:0] rx_next;
    logic [23:0] tx_reg;
    logic [5:0]  idx_reg;
    logic        any_done_reg;
    logic        sdo_reg;
    logic        oe_n_reg;
    logic        active;
    logic        sclk_rise;
    logic        sclk_fall;
    logic        cs_fall;
    logic        cs_rise;
    logic        crc_en;
    logic        burst_on;
    logic [5:0]  cmd_len;
    logic        end_evt;
    cmd_t        end_cmd;
    logic        crc_ok;
    logic        is_clear;
    logic        bad_addr;
    logic        do_write;
    logic        soft_rst;
    logic        count_bad;
    logic [7:0]  rd_val;
    logic        crc_frame_reg;
    logic        burst_frame_reg;

    // ----------------------------------------
    // Functions
    // ----------------------------------------
    // CRC-8 over one 16-bit word, MSB first
    function automatic logic [7:0] crc8(input logic [15:0] d);
        logic [7:0] c;
        c = CRC_SEED;
        for (int i = 15; i >= 0; i--) begin
            c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? CRC_POLY : 8'h00);
        end
        return c;
    endfunction

    // Addresses that accept a write
    function automatic logic writable(input logic [6:0] a);
        return (a == ADDR_SW) || (a == ADDR_CFG) ||
               (a == ADDR_BURST) || (a == ADDR_KEY);
    endfunction

    // ----------------------------------------
    // Pin synchronisers and edge detection
    // ----------------------------------------
    // Two stages before any logic; the third stage gives edges
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            sync1_reg     <= PINS_IDLE;
            sync2_reg     <= PINS_IDLE;
            sclk_prev_reg <= 1'b0;
            cs_prev_reg   <= 1'b1;
            oe_n_reg      <= 1'b1;
        end else begin
            sync1_reg     <= '{sclk: sclk, cs_n: cs_n, sdi: sdi};
            sync2_reg     <= sync1_reg;
            sclk_prev_reg <= sync2_reg.sclk;
            cs_prev_reg   <= sync2_reg.cs_n;
            oe_n_reg      <= sync2_reg.cs_n;       // Driver enabled while selected
        end
    end

    // Edges in the select's first cycle are dropped so they never race the frame start
    assign active    = !sync2_reg.cs_n && !cs_prev_reg;
    assign sclk_rise = active && sync2_reg.sclk && !sclk_prev_reg;
    assign sclk_fall = active && !sync2_reg.sclk && sclk_prev_reg;
    assign cs_fall   = !sync2_reg.cs_n && cs_prev_reg;
    assign cs_rise   = sync2_reg.cs_n && !cs_prev_reg;

    // ----------------------------------------
    // Command decode
    // ----------------------------------------
    assign crc_en   = crc_frame_reg;
    assign burst_on = burst_frame_reg;
    assign cmd_len  = crc_en ? LEN_CRC : LEN_PLAIN;
    assign rx_next  = {rx_reg[22:0], sync2_reg.sdi};
    assign end_evt  = sclk_rise && (idx_reg == cmd_len - 6'h01);
    assign end_cmd  = crc_en ? rx_next[23:8] : rx_next[15:0];
    // CRC byte trails the command word
    assign crc_ok   = !crc_en || (crc8(end_cmd) == rx_next[7:0]);
    assign is_clear = (end_cmd == CLEAR_WORD);
    // Reads of absent registers and writes to read-only ones are bad
    assign bad_addr = !is_clear && (end_cmd.rd
                    ? !(writable(end_cmd.addr) || end_cmd.addr == ADDR_FLAGS)
                    : !writable(end_cmd.addr));
    // A write only lands on a whole, CRC-clean command
    assign do_write = end_evt && crc_ok && !end_cmd.rd && !is_clear
                    && writable(end_cmd.addr);
    assign soft_rst = do_write && end_cmd.addr == ADDR_KEY
                    && key_reg == KEY_FIRST && end_cmd.data == KEY_SECOND;

    // ----------------------------------------
    // Control registers
    // ----------------------------------------
    // Register writes; a matched key pair reopens all switches and restores defaults
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            sw_reg    <= SW_RST;
            cfg_reg   <= CFG_RST;
            burst_reg <= BURST_RST;
            key_reg   <= KEY_RST;
        end else if (soft_rst) begin
            sw_reg    <= SW_RST;
            cfg_reg   <= CFG_RST;
            burst_reg <= BURST_RST;
            key_reg   <= KEY_RST;
        end else if (do_write) begin
            unique case (end_cmd.addr)
                ADDR_SW:    sw_reg    <= end_cmd.data;
                ADDR_CFG:   cfg_reg   <= end_cmd.data & CFG_MASK;
                ADDR_BURST: burst_reg <= end_cmd.data & BURST_MASK;
                ADDR_KEY:   key_reg   <= end_cmd.data;               // Last key kept to match the pair
                default:    ;
            endcase
        end
    end

    // ----------------------------------------
    // Error flags
    // ----------------------------------------
    // Burst frames must end on a command boundary with at least one command
    assign count_bad = burst_on ? (idx_reg != 6'h00 || !any_done_reg)
                                : (idx_reg != cmd_len);

    // Clear first, then sets, so an event in the clearing cycle survives
    always_comb begin
        flags_next = flags_reg;
        if (soft_rst || (end_evt && is_clear && crc_ok)) begin
            flags_next = FLAGS_RST;
        end
        if (end_evt && !crc_ok) begin
            flags_next[FLAG_CRC] = 1'b1;
        end
        if (end_evt && crc_ok && bad_addr && cfg_reg[CFG_RW_BIT]) begin
            flags_next[FLAG_RW] = 1'b1;
        end
        if (cs_rise && cfg_reg[CFG_SCLK_BIT] && count_bad) begin
            flags_next[FLAG_SCLK] = 1'b1;
        end
    end

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            flags_reg <= FLAGS_RST;
        end else begin
            flags_reg <= flags_next;
        end
    end

    // ----------------------------------------
    // Frame sequencing
    // ----------------------------------------
    // Clock count within the current command; saturates outside burst
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            idx_reg         <= 6'h00;
            any_done_reg    <= 1'b0;
            crc_frame_reg   <= CFG_RST[CFG_CRC_BIT];
            burst_frame_reg <= BURST_RST[BURST_BIT];
        end else if (cs_fall) begin
            idx_reg         <= 6'h00;
            any_done_reg    <= 1'b0;
            crc_frame_reg   <= cfg_reg[CFG_CRC_BIT];  // Format held per frame, so a write to it cannot miscount
            burst_frame_reg <= burst_reg[BURST_BIT];
        end else if (end_evt) begin
            any_done_reg <= 1'b1;
            idx_reg      <= burst_on ? 6'h00 : idx_reg + 6'h01;
        end else if (sclk_rise && idx_reg != IDX_MAX) begin
            idx_reg <= idx_reg + 6'h01;
        end
    end

    // Receive shifter
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            rx_reg <= 24'h000000;
        end else if (sclk_rise) begin
            rx_reg <= rx_next;
        end
    end

    // ----------------------------------------
    // Read path
    // ----------------------------------------
    // Read mux on the address as its last bit arrives; absent addresses answer zero
    always_comb begin
        unique case (rx_next[6:0])
            ADDR_SW:    rd_val = sw_reg;
            ADDR_CFG:   rd_val = cfg_reg;
            ADDR_FLAGS: rd_val = flags_reg;
            ADDR_BURST: rd_val = burst_reg;
            ADDR_KEY:   rd_val = key_reg;
            default:    rd_val = 8'h00;
        endcase
    end

    // Answer word: alignment, data caught after the address byte, CRC
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            tx_reg <= 24'h000000;
        end else if (cs_fall || (end_evt && burst_on)) begin
            tx_reg <= {ALIGN_BYTE, 16'h0000};
        end else if (sclk_rise && idx_reg == IDX_ADDR) begin
            tx_reg <= {ALIGN_BYTE, rd_val, crc8({ALIGN_BYTE, rd_val})};
        end
    end

    // Data out changes on falling edges, first bit ready at select
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            sdo_reg <= 1'b0;
        end else if (cs_fall) begin
            sdo_reg <= ALIGN_BYTE[7];
        end else if (sclk_fall) begin
            sdo_reg <= (idx_reg < LEN_CRC) ? tx_reg[5'h17 - idx_reg[4:0]] : 1'b0;
        end
    end

    assign sdo_out      = sdo_reg;
    assign sdo_oe_n     = oe_n_reg;
    assign switch_close = sw_reg;

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);

    property p_sw_write;
        do_write && end_cmd.addr == ADDR_SW && !soft_rst |=> switch_close == $past(end_cmd.data);
    endproperty
    a_sw_write: assert property (p_sw_write) else $error("switch write lost");
    property p_soft_rst;
        soft_rst |=> sw_reg == SW_RST && cfg_reg == CFG_RST;
    endproperty
    a_soft_rst: assert property (p_soft_rst) else $error("soft reset missed");
    property p_rst_cfg;
        $fell(sys_rst) |-> cfg_reg == CFG_RST;
    endproperty
    a_rst_cfg: assert property (@(posedge mclk) p_rst_cfg) else $error("config reset");
    property p_rw_off;
        end_evt && !cfg_reg[CFG_RW_BIT] && !is_clear && !soft_rst |=> $stable(flags_reg[FLAG_RW]);
    endproperty
    a_rw_off: assert property (p_rw_off) else $error("address flag while off");
    property p_sclk_off;
        !cfg_reg[CFG_SCLK_BIT] && !end_evt |=> $stable(flags_reg[FLAG_SCLK]);
    endproperty
    a_sclk_off: assert property (p_sclk_off) else $error("count flag while off");
    property p_count_plain;
        cs_rise && cfg_reg[CFG_SCLK_BIT] && !burst_on && idx_reg != cmd_len |=> flags_reg[FLAG_SCLK];
    endproperty
    a_count_plain: assert property (p_count_plain) else $error("count error missed");
    property p_count_burst;
        cs_rise && burst_on && idx_reg == 6'h00 && any_done_reg && !end_evt |=> $stable(flags_reg[FLAG_SCLK]);
    endproperty
    a_count_burst: assert property (p_count_burst) else $error("burst count wrong");
    property p_crc_bad;
        end_evt && !crc_ok |=> flags_reg[FLAG_CRC] && $stable(sw_reg) ##1 $stable(sw_reg);
    endproperty
    a_crc_bad: assert property (p_crc_bad) else $error("bad CRC not caught");
    property p_resv;
        cfg_reg[7:3] == 5'h00 && burst_reg[7:1] == 7'h00;
    endproperty
    a_resv: assert property (p_resv) else $error("reserved bits set");
    property p_clear;
        end_evt && is_clear && crc_ok && !cs_rise |=> flags_reg == FLAGS_RST;
    endproperty
    a_clear: assert property (p_clear) else $error("clear failed");
    property p_ro_write;
        end_evt && crc_ok && !end_cmd.rd && end_cmd.addr == ADDR_FLAGS && cfg_reg[CFG_RW_BIT] |=> flags_reg[FLAG_RW];
    endproperty
    a_ro_write: assert property (p_ro_write) else $error("read-only write unflagged");
    property p_short;
        cs_rise && !burst_on && idx_reg < cmd_len && cfg_reg[CFG_SCLK_BIT] |=> flags_reg[FLAG_SCLK];
    endproperty
    a_short: assert property (p_short) else $error("short frame unflagged");
    property p_burst_wrap;
        end_evt && burst_on |=> idx_reg == 6'h00 [*2];
    endproperty
    a_burst_wrap: assert property (p_burst_wrap) else $error("burst did not wrap");

    c_write: cover property (do_write && end_cmd.addr == ADDR_SW);
    c_clear: cover property (end_evt && is_clear && crc_ok);
    c_burst: cover property (end_evt && burst_on ##[1:1000] end_evt);
    c_crc:   cover property (end_evt && crc_en && crc_ok);

endmodule

// ### verification/spi_host_model.sv
// Host microcontroller model that drives the serial port of the switch bank.
// Assumes mclk is the bench clock; one sclk period is 16 mclk (80 ns).
`timescale 1ns/1ps
module spi_host_model
    import spi_switch_pkg::*;
(
    input  wire logic mclk,
    output logic      sclk,
    output logic      cs_n,
    output logic      sdi,
    input  wire logic sdo_out,
    input  wire logic sdo_oe_n
);
    // ----------------------------------------
    // Data line as the host sees it
    // ----------------------------------------
    logic sdo_last = 1'b0;
    logic sdo_line;

    // A released line shows the inverse of its last bit, so a stale copy never passes
    always @(posedge mclk) begin
        if (!sdo_oe_n) begin
            sdo_last <= sdo_out;
        end
    end
    assign sdo_line = sdo_oe_n ? ~sdo_last : sdo_out;

    // Mode 0: clock idles low and stands still between frames
    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
        sdi  = 1'b0;
    end

    // ----------------------------------------
    // Frame engine
    // ----------------------------------------
    // Trailing check byte sent while checking is on
    function automatic logic [7:0] crc8(input logic [15:0] d);
        logic [7:0] c;
        c = CRC_SEED;
        for (int i = 15; i >= 0; i--) begin
            c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? CRC_POLY : 8'h00);
        end
        return c;
    endfunction

    // One chip-select frame of n bits, MSB first; sdo taken just before each rise
    task automatic xfer(input logic [47:0] tx, input int n, output logic [47:0] rx);
        rx = '0;
        @(posedge mclk);
        cs_n <= 1'b0;
        for (int i = n - 1; i >= 0; i--) begin
            sdi <= tx[i];
            repeat (7) @(posedge mclk);
            @(negedge mclk);
            rx = {rx[46:0], sdo_line};
            @(posedge mclk);
            sclk <= 1'b1;
            repeat (8) @(posedge mclk);
            sclk <= 1'b0;
        end
        // Tail leaves room for the flag update after chip-select rises
        repeat (8) @(posedge mclk);
        cs_n <= 1'b1;
        repeat (20) @(posedge mclk);
    endtask
endmodule

// ### verification/test_spi_switch_register_bank.sv
// Self-checking bench for the serial switch register bank.
// Assumes the host model drives the pins; expectations come from the register map.
`timescale 1ns/1ps
module test_spi_switch_register_bank
    import spi_switch_pkg::*;
;
    logic       mclk    = 1'b0;
    logic       sys_rst = 1'b1;
    logic       sclk;
    logic       cs_n;
    logic       sdi;
    logic       sdo_out;
    logic       sdo_oe_n;
    logic [7:0] switch_close;
    logic       crc_on  = 1'b0;
    logic [7:0] v;
    int         fail_count   = 0;
    int         total_checks = 0;

    always #2.5 mclk = ~mclk;

    spi_switch_register_bank u_dut (.mclk(mclk), .sys_rst(sys_rst), .sclk(sclk), .cs_n(cs_n), .sdi(sdi),
        .sdo_out(sdo_out), .sdo_oe_n(sdo_oe_n), .switch_close(switch_close));
    spi_host_model u_host (.mclk(mclk), .sclk(sclk), .cs_n(cs_n), .sdi(sdi), .sdo_out(sdo_out),
        .sdo_oe_n(sdo_oe_n));

    // ----------------------------------------
    // Shared helpers
    // ----------------------------------------
    task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
        total_checks++;
        if (got !== exp) begin
            $display("BAD %s expected %h seen %h", name, exp, got);
            fail_count++;
        end
    endtask

    task automatic raw(input logic [47:0] tx, input int n);
        logic [47:0] rx;
        u_host.xfer(tx, n, rx);
    endtask

    // Frame length follows the host's view of the check-byte setting
    task automatic send(input logic [15:0] c, output logic [7:0] d);
        logic [47:0] rx;
        if (crc_on) begin
            u_host.xfer({24'h0, c, u_host.crc8(c)}, 24, rx);
        end else begin
            u_host.xfer({32'h0, c}, 16, rx);
        end
        d = crc_on ? rx[15:8] : rx[7:0];
        check("align byte", ALIGN_BYTE, crc_on ? rx[23:16] : rx[15:8]);
        if (crc_on) begin
            check("answer crc", u_host.crc8(rx[23:8]), rx[7:0]);
        end
    endtask

    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        logic [7:0] dummy;
        send({1'b0, a, d}, dummy);
    endtask

    task automatic chk_reg(input logic [6:0] a, input logic [7:0] exp);
        logic [7:0] d;
        send({1'b1, a, 8'h00}, d);
        check("readback", exp, d);
    endtask

    task automatic clr();
        logic [7:0] dummy;
        send(CLEAR_WORD, dummy);
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_reset();
        check("switch pins", SW_RST, switch_close);
        check("sdo released", 8'h01, {7'h00, sdo_oe_n});
        chk_reg(ADDR_SW, 8'h00);
        chk_reg(ADDR_CFG, 8'h06);
        chk_reg(ADDR_FLAGS, 8'h00);
        // Software reset must bring the switches back open
        wr(ADDR_SW, 8'hFF);
        wr(ADDR_KEY, KEY_FIRST);
        wr(ADDR_KEY, KEY_SECOND);
        check("switch pins", 8'h00, switch_close);
    endtask

    task automatic t_switches();
        for (int i = 0; i < 8; i++) begin
            wr(ADDR_SW, 8'(1 << i));
            check("switch pins", 8'(1 << i), switch_close);
        end
        wr(ADDR_SW, 8'hA5);
        chk_reg(ADDR_SW, 8'hA5);
    endtask

    // Address checking off, then on; read-only target refused
    task automatic t_address();
        wr(ADDR_CFG, 8'h02);
        chk_reg(ADDR_CFG, 8'h02);
        chk_reg(7'h7F, 8'h00);
        chk_reg(ADDR_FLAGS, 8'h00);
        wr(ADDR_CFG, CFG_RST);
        chk_reg(7'h7F, 8'h00);
        chk_reg(ADDR_FLAGS, 8'h04);
        clr();
        chk_reg(ADDR_FLAGS, 8'h00);
        wr(ADDR_FLAGS, 8'hFF);
        chk_reg(ADDR_FLAGS, 8'h04);
        clr();
    endtask

    // Short and long frames with clock-count checking on, then a short frame with it off
    task automatic t_count();
        wr(ADDR_SW, 8'h0F);
        raw(48'h01F, 12);
        check("switch pins", 8'h0F, switch_close);
        chk_reg(ADDR_FLAGS, 8'h02);
        clr();
        raw(48'h01F00, 20);
        check("switch pins", 8'hF0, switch_close);
        chk_reg(ADDR_FLAGS, 8'h02);
        clr();
        wr(ADDR_CFG, 8'h04);
        raw(48'h01A, 12);
        check("switch pins", 8'hF0, switch_close);
        chk_reg(ADDR_FLAGS, 8'h00);
        wr(ADDR_CFG, CFG_RST);
    endtask

    task automatic t_crc();
        wr(ADDR_CFG, 8'h07);
        crc_on = 1'b1;
        wr(ADDR_SW, 8'h3C);
        check("switch pins", 8'h3C, switch_close);
        chk_reg(ADDR_CFG, 8'h07);
        raw({24'h0, 16'h0155, ~u_host.crc8(16'h0155)}, 24);
        check("switch pins", 8'h3C, switch_close);
        chk_reg(ADDR_FLAGS, 8'h01);
        raw({24'h0, CLEAR_WORD, ~u_host.crc8(CLEAR_WORD)}, 24);
        chk_reg(ADDR_FLAGS, 8'h01);
        clr();
        chk_reg(ADDR_FLAGS, 8'h00);
        raw(48'h0166, 16);
        check("switch pins", 8'h3C, switch_close);
        chk_reg(ADDR_FLAGS, 8'h02);
        clr();
        wr(ADDR_CFG, CFG_RST);
        crc_on = 1'b0;
    endtask

    task automatic t_burst();
        wr(ADDR_BURST, 8'h01);
        chk_reg(ADDR_BURST, 8'h01);
        raw(48'h01110122, 32);
        check("switch pins", 8'h22, switch_close);
        chk_reg(ADDR_FLAGS, 8'h00);
        raw(48'h013300, 24);
        check("switch pins", 8'h33, switch_close);
        chk_reg(ADDR_FLAGS, 8'h02);
        clr();
        wr(ADDR_BURST, 8'h00);
        raw(48'h01440155, 32);
        check("switch pins", 8'h44, switch_close);
        chk_reg(ADDR_FLAGS, 8'h02);
        clr();
    endtask

    // ----------------------------------------
    // Run control
    // ----------------------------------------
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // Hang guard well above the longest expected run
    initial begin
        repeat (100000) @(posedge mclk);
        fail_count++;
        $display("BAD watchdog expected done seen running");
        report_and_stop();
    end

    initial begin
        repeat (12) @(posedge mclk);
        sys_rst <= 1'b0;
        repeat (4) @(posedge mclk);
        t_reset();
        t_switches();
        t_address();
        t_count();
        t_crc();
        t_burst();
        report_and_stop();
    end
endmodule
